// ===== hdl/ubo_irq_status.sv
/*
 * Bulk OUT interrupt status logic of endpoint 2 with the status four
 * register, reached over an AHB-Lite slave with zero wait states.
 * Assumes serial engine event inputs are single-cycle pulses on clk.
 */
`timescale 1ns/1ps
`include "ubo_consts.svh"

module ubo_irq_status
	import ubo_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic se_rx_good,
	input wire logic se_rx_null,
	input wire logic se_nak_sent,
	input wire logic se_auto_set_req,
	input wire logic cpu_read_empty,
	input wire logic iface_supports_ep2,
	output logic fifo_toggle,
	output logic sie_fifo_full,
	output logic cpu_fifo_full,
	output logic endpoint_status_zero_ep2,
	output logic usb_irq_line_one,
	output logic usb_irq_line_two
);

	ubo_state_t st_ff;
	ubo_state_t nxt_st;
	logic buf_sie_full;
	logic buf_cpu_full;
	logic buf_toggle;
	logic buf_toggle_null;
	logic ep2_ok;
	logic [7:0] status_three;
	logic [7:0] status_four;
	logic addr_take;
	logic clr3_wr;
	logic clr4_wr;

	function automatic logic addr_hit(input logic [31:0] a, input logic [15:0] idx);
		addr_hit = (a == {14'h0000, idx, 2'b00});
	endfunction

	////////////////////////////////////////////////////////////////////////////
	ubo_rx_buffer u_rx_buffer
	(
		.clk(clk),
		.resetn(resetn),
		.rx_good(se_rx_good && ep2_ok),
		.rx_null(se_rx_null),
		.cpu_read_empty(cpu_read_empty),
		.sie_full(buf_sie_full),
		.cpu_full(buf_cpu_full),
		.toggle(buf_toggle),
		.toggle_null(buf_toggle_null)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register views
	always_comb
	begin
		ep2_ok = st_ff.ep_map[`UBO_BIT_MAP_EP2] && iface_supports_ep2;
		status_three = `UBO_RST_STATUS;
		// Endpoint bits of an unsupported endpoint read as zero
		status_three[`UBO_BIT_FULL] = st_ff.full && ep2_ok;
		status_three[`UBO_BIT_NULL] = st_ff.null_pkt && ep2_ok;
		status_three[`UBO_BIT_NAK] = st_ff.nak && ep2_ok;
		status_three[`UBO_BIT_DONE] = st_ff.done && ep2_ok;
		status_four = `UBO_RST_STATUS;
		status_four[`UBO_BIT_AUTO_REQ] = st_ff.auto_req;
	end

	assign addr_take = hsel && htrans[1] && hready;
	assign clr3_wr = st_ff.dph_wr && (st_ff.dph_idx == `UBO_IDX_CLEAR_THREE);
	assign clr4_wr = st_ff.dph_wr && (st_ff.dph_idx == `UBO_IDX_CLEAR_FOUR);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		nxt_st = st_ff;

		// Full: cleared by firmware first, then the toggle, set last wins
		if (clr3_wr && !hwdata[`UBO_BIT_FULL])
		begin
			nxt_st.full = 1'b0;
		end
		if (buf_toggle)
		begin
			nxt_st.full = 1'b0;
		end
		if (buf_sie_full && buf_cpu_full && ep2_ok && !buf_toggle)
		begin
			nxt_st.full = 1'b1;
		end

		if (clr3_wr && !hwdata[`UBO_BIT_NULL])
		begin
			nxt_st.null_pkt = 1'b0;
		end
		if (se_rx_good && se_rx_null && ep2_ok)
		begin
			nxt_st.null_pkt = 1'b1;
		end

		if (clr3_wr && !hwdata[`UBO_BIT_NAK])
		begin
			nxt_st.nak = 1'b0;
		end
		if (se_nak_sent && ep2_ok)
		begin
			nxt_st.nak = 1'b1;
		end

		// Done and endpoint status follow the CPU side; a null packet sets neither
		if ((clr3_wr && !hwdata[`UBO_BIT_DONE]) || cpu_read_empty)
		begin
			nxt_st.done = 1'b0;
		end
		if (cpu_read_empty)
		begin
			nxt_st.ep_status = 1'b0;
		end
		if (buf_toggle && !buf_toggle_null && ep2_ok)
		begin
			nxt_st.done = 1'b1;
			nxt_st.ep_status = 1'b1;
		end

		if (clr4_wr && !hwdata[`UBO_BIT_AUTO_REQ])
		begin
			nxt_st.auto_req = 1'b0;
		end
		if (se_auto_set_req)
		begin
			nxt_st.auto_req = 1'b1;
		end

		if (st_ff.dph_wr && (st_ff.dph_idx == `UBO_IDX_EP_MAP))
		begin
			nxt_st.ep_map = hwdata[7:0];
		end

		// Line two: pending from a change until firmware reads status four
		nxt_st.four_prev = status_four;
		if (addr_take && !hwrite && addr_hit(haddr, `UBO_IDX_STATUS_FOUR))
		begin
			nxt_st.irq_two = 1'b0;
		end
		if (status_four != st_ff.four_prev)
		begin
			nxt_st.irq_two = 1'b1;
		end

		// Address phase: latch target, prepare read data for the data phase
		nxt_st.dph_wr = addr_take && hwrite;
		nxt_st.dph_idx = 16'h0000;
		nxt_st.rdata = `UBO_RST_RDATA;
		if (addr_take)
		begin
			if (addr_hit(haddr, `UBO_IDX_STATUS_THREE))
			begin
				nxt_st.dph_idx = `UBO_IDX_STATUS_THREE;
				nxt_st.rdata = {24'h000000, status_three};
			end
			else if (addr_hit(haddr, `UBO_IDX_STATUS_FOUR))
			begin
				// Read-only: a write here lands on no storage
				nxt_st.dph_idx = `UBO_IDX_STATUS_FOUR;
				nxt_st.rdata = {24'h000000, status_four};
			end
			else if (addr_hit(haddr, `UBO_IDX_CLEAR_THREE))
			begin
				nxt_st.dph_idx = `UBO_IDX_CLEAR_THREE;
				nxt_st.rdata = {24'h000000, `UBO_CLEAR_READ};
			end
			else if (addr_hit(haddr, `UBO_IDX_CLEAR_FOUR))
			begin
				nxt_st.dph_idx = `UBO_IDX_CLEAR_FOUR;
				nxt_st.rdata = {24'h000000, `UBO_CLEAR_READ};
			end
			else if (addr_hit(haddr, `UBO_IDX_EP_MAP))
			begin
				nxt_st.dph_idx = `UBO_IDX_EP_MAP;
				nxt_st.rdata = {24'h000000, st_ff.ep_map};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_ff <= '0;
			st_ff.ep_map <= `UBO_RST_EP_MAP;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Zero wait states; unmapped addresses read zero and ignore writes
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_ff.rdata;
	assign fifo_toggle = buf_toggle;
	assign sie_fifo_full = buf_sie_full;
	assign cpu_fifo_full = buf_cpu_full;
	assign endpoint_status_zero_ep2 = st_ff.ep_status;
	assign usb_irq_line_one = |status_three;
	assign usb_irq_line_two = st_ff.irq_two;

endmodule

// ===== hdl/ubo_consts.svh
/*
 * Constants of the bulk OUT interrupt status block: register indices,
 * bit positions and reset values.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef UBO_CONSTS_SVH
`define UBO_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Full flag set when both FIFOs hold data
// - Full flag cleared when FIFOs toggle
// - Full flag one requests interrupt, resets zero
// - Any status four change activates line two
// - Status four read-only byte, writes ignored
// - Writing zero to clear bit clears status
// - Unsupported endpoint status bits read zero
////////////////////////////////////////////////////////////////////////////////

// Register indices; byte address is four times the index
`define UBO_IDX_STATUS_THREE 16'hff2a
`define UBO_IDX_STATUS_FOUR 16'hff2b
`define UBO_IDX_CLEAR_THREE 16'hff2c
`define UBO_IDX_CLEAR_FOUR 16'hff2d
`define UBO_IDX_EP_MAP 16'hff2e

// Status three bit positions
`define UBO_BIT_FULL 3
`define UBO_BIT_NULL 2
`define UBO_BIT_NAK 1
`define UBO_BIT_DONE 0
// Status four bit position
`define UBO_BIT_AUTO_REQ 5
// Endpoint mapping: endpoint 2 enabled
`define UBO_BIT_MAP_EP2 0

`define UBO_RST_STATUS 8'h00
`define UBO_RST_EP_MAP 8'h01
`define UBO_RST_RDATA 32'h0000_0000
`define UBO_CLEAR_READ 8'hff

`endif

// ===== hdl/ubo_pkg.sv
/*
 * Types of the bulk OUT interrupt status block: the packed state records.
 * Assumes the constants header is reachable by bare name.
 */
`include "ubo_consts.svh"

package ubo_pkg;

	typedef struct packed {
		logic sie_full;
		logic sie_null;
		logic cpu_full;
		logic toggle;
		logic toggle_null;
	} ubo_buf_state_t;

	typedef struct packed {
		logic full;
		logic null_pkt;
		logic nak;
		logic done;
		logic ep_status;
		logic auto_req;
		logic [7:0] ep_map;
		logic [7:0] four_prev;
		logic irq_two;
		logic dph_wr;
		logic [15:0] dph_idx;
		logic [31:0] rdata;
	} ubo_state_t;

endpackage

// ===== hdl/ubo_rx_buffer.sv
/*
 * Occupancy of the two-sided bulk receive buffer for endpoint 2.
 * Assumes the serial engine writes a packet only while its side is empty
 * and the CPU pulses cpu_read_empty once its side has been read out.
 */
`timescale 1ns/1ps

module ubo_rx_buffer
	import ubo_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic rx_good,
	input wire logic rx_null,
	input wire logic cpu_read_empty,
	output logic sie_full,
	output logic cpu_full,
	output logic toggle,
	output logic toggle_null
);

	ubo_buf_state_t st_ff;
	ubo_buf_state_t nxt_st;
	logic swap;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_st = st_ff;
		// Swap only when the CPU side is free, so no data is overwritten
		swap = st_ff.sie_full && !st_ff.cpu_full;
		nxt_st.toggle = swap;
		nxt_st.toggle_null = swap && st_ff.sie_null;
		if (cpu_read_empty)
		begin
			nxt_st.cpu_full = 1'b0;
		end
		if (swap)
		begin
			nxt_st.cpu_full = 1'b1;
			nxt_st.sie_full = 1'b0;
			nxt_st.sie_null = 1'b0;
		end
		else if (rx_good && !st_ff.sie_full)
		begin
			nxt_st.sie_full = 1'b1;
			nxt_st.sie_null = rx_null;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign sie_full = st_ff.sie_full;
	assign cpu_full = st_ff.cpu_full;
	assign toggle = st_ff.toggle;
	assign toggle_null = st_ff.toggle_null;

endmodule

// ===== tb/ubo_irq_status_asserts.sv
/*
 * Port checker of the bulk OUT status block.
 * Assumes it is bound to ubo_irq_status on a single clock.
 */
`timescale 1ns/1ps
`include "ubo_consts.svh"

module ubo_irq_status_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic se_rx_good,
	input wire logic iface_supports_ep2,
	input wire logic fifo_toggle,
	input wire logic sie_fifo_full,
	input wire logic cpu_fifo_full,
	input wire logic endpoint_status_zero_ep2,
	input wire logic usb_irq_line_one,
	input wire logic usb_irq_line_two
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);

	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus stalled or errored");
	byte_read_a: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	fill_swap_a: assert property (se_rx_good && iface_supports_ep2 && !sie_fifo_full && !cpu_fifo_full
		|=> sie_fifo_full ##1 fifo_toggle && !sie_fifo_full) else $error("packet not swapped");
	toggle_state_a: assert property (fifo_toggle |-> cpu_fifo_full && !sie_fifo_full ##1 !fifo_toggle)
		else $error("bad state at swap");
	done_after_a: assert property ($rose(endpoint_status_zero_ep2) |-> $past(fifo_toggle))
		else $error("status rose without swap");
	both_full_a: assert property ((sie_fifo_full && cpu_fifo_full && iface_supports_ep2) [*2]
		|-> usb_irq_line_one) else $error("full gave no request");
	no_map_a: assert property (se_rx_good && !iface_supports_ep2 && !sie_fifo_full |=> !sie_fifo_full)
		else $error("unmapped packet taken");
	line_two_hold_a: assert property (usb_irq_line_two && !(hsel && htrans[1] && hready && !hwrite
		&& haddr == {14'h0000, `UBO_IDX_STATUS_FOUR, 2'b00}) |=> usb_irq_line_two)
		else $error("line two dropped unread");
	reset_zero_a: assert property (disable iff (1'b0) !resetn |=> !usb_irq_line_one && !cpu_fifo_full
		&& !usb_irq_line_two) else $error("reset left state");
endmodule

////////////////////////////////////////////////////////////////////////////////
bind ubo_irq_status ubo_irq_status_asserts u_chk (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .hrdata, .se_rx_good, .iface_supports_ep2, .fifo_toggle, .sie_fifo_full, .cpu_fifo_full,
	.endpoint_status_zero_ep2, .usb_irq_line_one, .usb_irq_line_two);

// ===== tb/ubo_host_model.sv
/*
 * Host stand-in: turns one request kind into one serial engine event.
 * Assumes go is held for exactly one clock per event.
 */
`timescale 1ns/1ps

module ubo_host_model (
	input wire logic go,
	input wire logic [1:0] kind,
	output logic se_rx_good,
	output logic se_rx_null,
	output logic se_nak_sent,
	output logic se_auto_set_req
);
	// Kinds: 0 data, 1 null data, 2 NAKed token, 3 auto SET
	assign se_rx_good = go && !kind[1];
	assign se_rx_null = go && kind == 2'h1;
	assign se_nak_sent = go && kind == 2'h2;
	assign se_auto_set_req = go && kind == 2'h3;
endmodule

// ===== tb/ubo_irq_status_test.sv
/*
 * Self-checking bench of the bulk OUT status block.
 * Assumes design, checker and host model compiled before it.
 */
`timescale 1ns/1ps
`include "ubo_consts.svh"

module ubo_irq_status_test;
	typedef struct {logic [15:0] idx; logic [7:0] exp;} ubo_row_t;
	logic clk, resetn, hsel, hwrite, go, cpu_read_empty, iface_supports_ep2, hresp;
	logic se_rx_good, se_rx_null, se_nak_sent, se_auto_set_req, fifo_toggle, sie_fifo_full;
	logic cpu_fifo_full, ep_stat, irq_one, irq_two;
	wire logic hready;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, kind;
	int fails = 0;
	int total_checks = 0;
	ubo_row_t rows[6] = '{'{`UBO_IDX_STATUS_THREE, `UBO_RST_STATUS}, '{`UBO_IDX_STATUS_FOUR, `UBO_RST_STATUS},
		'{`UBO_IDX_CLEAR_THREE, `UBO_CLEAR_READ}, '{`UBO_IDX_CLEAR_FOUR, `UBO_CLEAR_READ},
		'{`UBO_IDX_EP_MAP, `UBO_RST_EP_MAP}, '{16'h0010, 8'h00}};

	ubo_host_model u_host (.go, .kind, .se_rx_good, .se_rx_null, .se_nak_sent, .se_auto_set_req);
	ubo_irq_status u_dut (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
		.hreadyout(hready), .hrdata, .hresp, .se_rx_good, .se_rx_null, .se_nak_sent, .se_auto_set_req,
		.cpu_read_empty, .iface_supports_ep2, .fifo_toggle, .sie_fifo_full, .cpu_fifo_full,
		.endpoint_status_zero_ep2(ep_stat), .usb_irq_line_one(irq_one), .usb_irq_line_two(irq_two));

	////////////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {14'h0, idx, 2'h0};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask

	// Host event or CPU drain, then time for the swap to settle
	task automatic ev(input logic [1:0] k, input logic e);
		@(posedge clk);
		go <= !e;
		cpu_read_empty <= e;
		kind <= k;
		@(posedge clk);
		go <= 1'b0;
		cpu_read_empty <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial
	begin
		repeat (3000) @(posedge clk);
		fails++;
		test_done();
	end

	initial
	begin
		{resetn, hsel, hwrite, go, cpu_read_empty, iface_supports_ep2} = '0;
		{htrans, kind, haddr, hwdata} = '0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		foreach (rows[i])
		begin
			bus(1'b0, rows[i].idx, 8'h00);
			chk(rd[7:0], rows[i].exp);
		end
		$display("register rows done");
		ev(2'h0, 1'b0);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h00);
		iface_supports_ep2 <= 1'b1;
		ev(2'h0, 1'b0);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h01);
		chk({7'h0, irq_one}, 8'h01);
		chk({7'h0, ep_stat}, 8'h01);
		ev(2'h0, 1'b0);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h09);
		chk({6'h0, sie_fifo_full, cpu_fifo_full}, 8'h03);
		ev(2'h0, 1'b1);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h01);
		ev(2'h0, 1'b1);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h00);
		chk({7'h0, ep_stat}, 8'h00);
		$display("receive flow done");
		ev(2'h1, 1'b0);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h04);
		chk({7'h0, ep_stat}, 8'h00);
		ev(2'h0, 1'b1);
		ev(2'h2, 1'b0);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h06);
		bus(1'b1, `UBO_IDX_CLEAR_THREE, 8'hfb);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h02);
		bus(1'b1, `UBO_IDX_CLEAR_THREE, 8'h00);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h00);
		chk({7'h0, irq_one}, 8'h00);
		$display("null and nak done");
		bus(1'b1, `UBO_IDX_STATUS_FOUR, 8'hff);
		ev(2'h3, 1'b0);
		chk({7'h0, irq_two}, 8'h01);
		bus(1'b0, `UBO_IDX_STATUS_FOUR, 8'h00);
		chk(rd[7:0], 8'h20);
		repeat (2) @(posedge clk);
		chk({7'h0, irq_two}, 8'h00);
		bus(1'b1, `UBO_IDX_CLEAR_FOUR, 8'hff);
		bus(1'b0, `UBO_IDX_STATUS_FOUR, 8'h00);
		chk(rd[7:0], 8'h20);
		bus(1'b1, `UBO_IDX_CLEAR_FOUR, 8'hdf);
		repeat (4) @(posedge clk);
		chk({7'h0, irq_two}, 8'h01);
		bus(1'b0, `UBO_IDX_STATUS_FOUR, 8'h00);
		chk(rd[7:0], 8'h00);
		$display("status four done");
		ev(2'h2, 1'b0);
		ev(2'h3, 1'b0);
		bus(1'b1, `UBO_IDX_EP_MAP, 8'h00);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h00);
		chk({7'h0, irq_two}, 8'h01);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		chk({6'h0, irq_one, irq_two}, 8'h00);
		bus(1'b0, `UBO_IDX_STATUS_THREE, 8'h00);
		chk(rd[7:0], 8'h00);
		bus(1'b0, `UBO_IDX_STATUS_FOUR, 8'h00);
		chk(rd[7:0], 8'h00);
		bus(1'b0, `UBO_IDX_EP_MAP, 8'h00);
		chk(rd[7:0], 8'h01);
		$display("reset done");
		test_done();
	end
endmodule
